//--- shared/mwm_pkg.sv
package mwm_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Object indices
    localparam logic [15:0] IDX_FE_TIMEOUT     = 16'h6066;
    localparam logic [15:0] IDX_POS_WINDOW     = 16'h6067;
    localparam logic [15:0] IDX_POS_TIME       = 16'h6068;
    localparam logic [15:0] IDX_SPEED_SETPOINT = 16'h606B;
    localparam logic [15:0] IDX_SPEED_MEASURED = 16'h606C;
    localparam logic [15:0] IDX_VEL_WINDOW     = 16'h606D;
    localparam logic [15:0] IDX_VEL_TIME       = 16'h606E;
    localparam logic [15:0] IDX_THR            = 16'h606F;
    localparam logic [15:0] IDX_THR_TIME       = 16'h6070;

    ////////////////////////////////////////////////////////////////////////
    // Reset values
    localparam logic [15:0] RST_FE_TIMEOUT = 16'h0064;
    localparam logic [31:0] RST_FE_WINDOW  = 32'h00000100;
    localparam logic [31:0] RST_POS_WINDOW = 32'h0000000A;
    localparam logic [15:0] RST_POS_TIME   = 16'h0064;
    localparam logic [31:0] RST_SPEED      = 32'h00000000;
    localparam logic [15:0] RST_VEL_WINDOW = 16'h001E;
    localparam logic [15:0] RST_VEL_TIME   = 16'h0000;
    localparam logic [15:0] RST_THR        = 16'h0000;
    localparam logic [15:0] RST_THR_TIME   = 16'h0000;

    // Window value that switches a check off
    localparam logic [31:0] WINDOW_OFF = 32'hFFFFFFFF;

    ////////////////////////////////////////////////////////////////////////
    // Status bit positions
    localparam int BIT_TARGET_REACHED = 10;
    localparam int BIT_ZERO_SPEED     = 12;
    localparam int BIT_FOLLOW_ERR     = 13;

    // Operating modes
    localparam logic [7:0] MODE_PROFILE_POS = 8'h01;
    localparam logic [7:0] MODE_PROFILE_VEL = 8'h03;
    localparam logic [7:0] MODE_INTERP_POS  = 8'h07;

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int CLK_PERIOD_NS     = 40;
    localparam int MS_PERIOD_NS      = 1000000;
    localparam int MS_CYCLES_DEFAULT = MS_PERIOD_NS / CLK_PERIOD_NS;
    localparam int DIV_W             = 16;
    localparam int MS_CNT_W          = 16;
    localparam logic [15:0] MS_CNT_MAX = 16'hFFFF;

    // Window check channels
    localparam int CH_FE  = 0;
    localparam int CH_POS = 1;
    localparam int CH_VEL = 2;
    localparam int CH_THR = 3;
    localparam int NUM_CH = 4;

endpackage

//--- design/mwm_window_timer.sv
`timescale 1ns/1ps
module mwm_window_timer (
    // Clock and reset
    input  wire logic                          clk,
    input  wire logic                          rst_n,
    // Condition and limit
    input  wire logic                          msTick,
    input  wire logic                          holdCond,
    input  wire logic [mwm_pkg::MS_CNT_W-1:0]  limitMs,
    // Result
    output logic                               reached
);
    import mwm_pkg::*;

    typedef struct packed {
        logic [MS_CNT_W-1:0] count;
    } mwm_timer_state_t;

    mwm_timer_state_t stReg;
    mwm_timer_state_t stNext;

    always_comb begin
        stNext = stReg;
        if (!holdCond) begin
            stNext.count = '0;
        end else if (msTick && stReg.count != MS_CNT_MAX) begin
            // Saturates so a long hold never wraps back below the limit
            stNext.count = stReg.count + 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stReg.count <= '0;
        end else begin
            stReg <= stNext;
        end
    end

    // Strictly longer than the programmed time
    assign reached = holdCond && (stReg.count > limitMs);

    ////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_count_restart: assert property (!holdCond |=> stReg.count == 16'h0000)
        else $error("hold counter not restarted");
    a_count_step: assert property (
        holdCond && msTick && stReg.count != MS_CNT_MAX
        |=> stReg.count == $past(stReg.count) + 16'h0001)
        else $error("hold counter missed a tick");
endmodule

//--- design/mwm_window_monitor.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////////////
////////////////////////////////////////////////////////////////////////////////
module mwm_window_monitor #(
    parameter int MS_CYCLES = mwm_pkg::MS_CYCLES_DEFAULT
) (
    // Clock and reset
    input  wire logic               clk,
    input  wire logic               rst_n,
    // Object access
    input  wire logic               objRdEn,
    input  wire logic               objWrEn,
    input  wire logic [15:0]        objIndex,
    input  wire logic [31:0]        objWrData,
    output logic      [31:0]        objRdData,
    output logic                    objAck,
    output logic                    objAbort,
    // Motion quantities
    input  wire logic [7:0]         opMode,
    input  wire logic signed [31:0] positionDemand,
    input  wire logic signed [31:0] positionActual,
    input  wire logic signed [31:0] targetPosition,
    input  wire logic signed [31:0] speedDemand,
    input  wire logic signed [31:0] speedActual,
    input  wire logic signed [31:0] targetSpeed,
    input  wire logic [31:0]        followErrWindow,
    input  wire logic               feReactionEn,
    // Status
    output logic [15:0]             statusBits,
    output logic                    errorLogPulse
);
    import mwm_pkg::*;

    typedef struct packed {
        logic [15:0]       feTimeout;
        logic [31:0]       posWindow;
        logic [15:0]       posTime;
        logic [15:0]       velWindow;
        logic [15:0]       velTime;
        logic [15:0]       thr;
        logic [15:0]       thrTime;
        logic [31:0]       speedAct;
        logic [31:0]       rdData;
        logic              ack;
        logic              abort;
        logic [DIV_W-1:0]  divCnt;
        logic              msTick;
        logic              followErr;
        logic              targetReached;
        logic              zeroSpeed;
        logic              errLog;
    } mwm_state_t;

    mwm_state_t stReg;
    mwm_state_t stNext;

    logic [NUM_CH-1:0]   holdCond;
    logic [MS_CNT_W-1:0] limitMs [NUM_CH];
    logic [NUM_CH-1:0]   reached;
    logic [32:0]         feDev;
    logic [32:0]         posDev;
    logic [32:0]         velDev;
    logic [32:0]         spdMag;
    logic                posMode;
    logic                pvMode;

    // 33 bits so the difference of two extreme values cannot overflow
    function automatic logic [32:0] absDiff(input logic [31:0] a, input logic [31:0] b);
        logic [32:0] d;
        d = {a[31], a} - {b[31], b};
        return d[32] ? ({1'b0, 32'h00000000} - d) : d;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Compare conditions
    assign feDev  = absDiff(positionActual, positionDemand);
    assign posDev = absDiff(positionActual, targetPosition);
    assign velDev = absDiff(stReg.speedAct, targetSpeed);
    assign spdMag = absDiff(stReg.speedAct, 32'h00000000);

    // Target reached means a different check in each mode family
    assign posMode = (opMode == MODE_PROFILE_POS) || (opMode == MODE_INTERP_POS);
    assign pvMode  = (opMode == MODE_PROFILE_VEL);

    // Window is a port; its object lives outside this map
    assign holdCond[CH_FE]  = (followErrWindow != WINDOW_OFF)
                              && (feDev > {1'b0, followErrWindow});
    assign holdCond[CH_POS] = posMode && (stReg.posWindow != WINDOW_OFF)
                              && (posDev < {1'b0, stReg.posWindow});
    assign holdCond[CH_VEL] = pvMode && (velDev < {1'b0, 16'h0000, stReg.velWindow});
    assign holdCond[CH_THR] = spdMag > {1'b0, 16'h0000, stReg.thr};

    assign limitMs[CH_FE]  = stReg.feTimeout;
    assign limitMs[CH_POS] = stReg.posTime;
    assign limitMs[CH_VEL] = stReg.velTime;
    assign limitMs[CH_THR] = stReg.thrTime;

    // One timer per check so no two checks ever share a count
    generate
        for (genvar ch = 0; ch < NUM_CH; ch++) begin : gTimer
            mwm_window_timer uTimer (
                .clk      (clk),
                .rst_n    (rst_n),
                .msTick   (stReg.msTick),
                .holdCond (holdCond[ch]),
                .limitMs  (limitMs[ch]),
                .reached  (reached[ch])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Next state
    always_comb begin
        stNext        = stReg;
        stNext.ack    = 1'b0;
        stNext.abort  = 1'b0;
        stNext.errLog = 1'b0;

        // Millisecond tick divider
        // Free-running, so a hold may meet its first tick anywhere in 1 ms
        if (stReg.divCnt == DIV_W'(MS_CYCLES - 1)) begin
            stNext.divCnt = '0;
            stNext.msTick = 1'b1;
        end else begin
            stNext.divCnt = stReg.divCnt + 16'h0001;
            stNext.msTick = 1'b0;
        end

        // Compares see the measured speed one cycle late
        stNext.speedAct = speedActual;

        // Write takes precedence over a simultaneous read
        if (objWrEn) begin
            stNext.ack = 1'b1;
            case (objIndex)
                IDX_FE_TIMEOUT: stNext.feTimeout = objWrData[15:0];
                IDX_POS_WINDOW: stNext.posWindow = objWrData;
                IDX_POS_TIME:   stNext.posTime   = objWrData[15:0];
                IDX_VEL_WINDOW: stNext.velWindow = objWrData[15:0];
                IDX_VEL_TIME:   stNext.velTime   = objWrData[15:0];
                IDX_THR:        stNext.thr       = objWrData[15:0];
                IDX_THR_TIME:   stNext.thrTime   = objWrData[15:0];
                // Read-only and unknown objects refuse writes
                default: begin
                    stNext.ack   = 1'b0;
                    stNext.abort = 1'b1;
                end
            endcase
        end else if (objRdEn) begin
            stNext.ack = 1'b1;
            case (objIndex)
                IDX_FE_TIMEOUT:     stNext.rdData = {16'h0000, stReg.feTimeout};
                IDX_POS_WINDOW:     stNext.rdData = stReg.posWindow;
                IDX_POS_TIME:       stNext.rdData = {16'h0000, stReg.posTime};
                IDX_SPEED_SETPOINT: stNext.rdData = speedDemand;
                IDX_SPEED_MEASURED: stNext.rdData = stReg.speedAct;
                IDX_VEL_WINDOW:     stNext.rdData = {16'h0000, stReg.velWindow};
                IDX_VEL_TIME:       stNext.rdData = {16'h0000, stReg.velTime};
                IDX_THR:            stNext.rdData = {16'h0000, stReg.thr};
                IDX_THR_TIME:       stNext.rdData = {16'h0000, stReg.thrTime};
                default: begin
                    stNext.ack    = 1'b0;
                    stNext.abort  = 1'b1;
                    stNext.rdData = 32'h00000000;
                end
            endcase
        end

        // Status evaluation
        stNext.followErr = reached[CH_FE];
        if (posMode) begin
            stNext.targetReached = reached[CH_POS];
        end else if (pvMode) begin
            stNext.targetReached = reached[CH_VEL];
        end else begin
            stNext.targetReached = 1'b0;
        end
        // Zero-speed bit is judged in every mode
        stNext.zeroSpeed = !reached[CH_THR];

        // One entry per onset, not per cycle of the fault
        stNext.errLog = reached[CH_FE] && !stReg.followErr && feReactionEn;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stReg.feTimeout     <= RST_FE_TIMEOUT;
            stReg.posWindow     <= RST_POS_WINDOW;
            stReg.posTime       <= RST_POS_TIME;
            stReg.velWindow     <= RST_VEL_WINDOW;
            stReg.velTime       <= RST_VEL_TIME;
            stReg.thr           <= RST_THR;
            stReg.thrTime       <= RST_THR_TIME;
            stReg.speedAct      <= RST_SPEED;
            stReg.rdData        <= 32'h00000000;
            stReg.ack           <= 1'b0;
            stReg.abort         <= 1'b0;
            stReg.divCnt        <= '0;
            stReg.msTick        <= 1'b0;
            stReg.followErr     <= 1'b0;
            stReg.targetReached <= 1'b0;
            stReg.zeroSpeed     <= 1'b1;
            stReg.errLog        <= 1'b0;
        end else begin
            stReg <= stNext;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs
    assign objRdData     = stReg.rdData;
    assign objAck        = stReg.ack;
    assign objAbort      = stReg.abort;
    assign errorLogPulse = stReg.errLog;

    always_comb begin
        statusBits                     = 16'h0000;
        statusBits[BIT_FOLLOW_ERR]     = stReg.followErr;
        statusBits[BIT_TARGET_REACHED] = stReg.targetReached;
        statusBits[BIT_ZERO_SPEED]     = stReg.zeroSpeed;
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_fe_window_off: assert property (
        followErrWindow == WINDOW_OFF |=> !statusBits[BIT_FOLLOW_ERR])
        else $error("following error flagged while monitoring off");

    a_fe_needs_deviation: assert property (
        !holdCond[CH_FE] |=> !statusBits[BIT_FOLLOW_ERR])
        else $error("following error without deviation");

    a_fe_strict: assert property (
        feDev == {1'b0, followErrWindow} |=> !statusBits[BIT_FOLLOW_ERR])
        else $error("following error flagged at the window edge");

    a_pos_window_off: assert property (
        posMode && stReg.posWindow == WINDOW_OFF |=> !statusBits[BIT_TARGET_REACHED])
        else $error("position reached while monitoring off");

    a_pos_needs_window: assert property (
        posMode && !holdCond[CH_POS] |=> !statusBits[BIT_TARGET_REACHED])
        else $error("position reached outside its window");

    a_pos_strict: assert property (
        posMode && posDev == {1'b0, stReg.posWindow} |=> !statusBits[BIT_TARGET_REACHED])
        else $error("position reached at the window edge");

    a_vel_needs_window: assert property (
        pvMode && !holdCond[CH_VEL] |=> !statusBits[BIT_TARGET_REACHED])
        else $error("speed reached outside its window");

    a_reach_mode_gate: assert property (
        !posMode && !pvMode |=> !statusBits[BIT_TARGET_REACHED])
        else $error("target reached outside its modes");

    a_zero_speed_idle: assert property (
        spdMag <= {1'b0, 16'h0000, stReg.thr} |=> statusBits[BIT_ZERO_SPEED])
        else $error("zero speed bit cleared below threshold");

    a_zero_speed_time: assert property (
        holdCond[CH_THR] && stReg.thrTime == 16'h0000 && stReg.msTick
        ##1 holdCond[CH_THR] && stReg.thrTime == 16'h0000
        |=> !statusBits[BIT_ZERO_SPEED])
        else $error("zero speed bit not cleared after threshold time");

    a_status_spare: assert property (
        (statusBits & 16'hCBFF) == 16'h0000)
        else $error("spare status bit set");

    a_err_log_onset: assert property (
        $rose(statusBits[BIT_FOLLOW_ERR]) && $past(feReactionEn) |-> errorLogPulse)
        else $error("following error onset not logged");

    a_err_log_gate: assert property (
        errorLogPulse |-> statusBits[BIT_FOLLOW_ERR] && $past(feReactionEn))
        else $error("error entry without a following error");

    a_speed_read: assert property (
        objRdEn && !objWrEn && objIndex == IDX_SPEED_SETPOINT
        |=> objAck && objRdData == $past(speedDemand))
        else $error("speed setpoint read mismatch");

    a_setpoint_write: assert property (
        objWrEn && objIndex == IDX_SPEED_SETPOINT |=> objAbort && !objAck)
        else $error("write to speed setpoint not refused");

    a_ro_write: assert property (
        objWrEn && objIndex == IDX_SPEED_MEASURED |=> objAbort && !objAck)
        else $error("write to measured speed not refused");

    a_ack_single: assert property (objAck |=> !objAck || $past(objRdEn || objWrEn))
        else $error("acknowledge without request");

    // Host writes land in the register one cycle after the request
    a_fe_timeout_write: assert property (
        objWrEn && objIndex == IDX_FE_TIMEOUT |=> stReg.feTimeout == $past(objWrData[15:0]))
        else $error("timeout write lost");

    a_pos_window_write: assert property (
        objWrEn && objIndex == IDX_POS_WINDOW |=> stReg.posWindow == $past(objWrData))
        else $error("position window write lost");

    a_pos_time_write: assert property (
        objWrEn && objIndex == IDX_POS_TIME |=> stReg.posTime == $past(objWrData[15:0]))
        else $error("position time write lost");

    a_vel_window_write: assert property (
        objWrEn && objIndex == IDX_VEL_WINDOW |=> stReg.velWindow == $past(objWrData[15:0]))
        else $error("velocity window write lost");

    a_vel_time_write: assert property (
        objWrEn && objIndex == IDX_VEL_TIME |=> stReg.velTime == $past(objWrData[15:0]))
        else $error("velocity time write lost");

    a_thr_write: assert property (
        objWrEn && objIndex == IDX_THR |=> stReg.thr == $past(objWrData[15:0]))
        else $error("threshold write lost");

    a_thr_time_write: assert property (
        objWrEn && objIndex == IDX_THR_TIME |=> stReg.thrTime == $past(objWrData[15:0]))
        else $error("threshold time write lost");

    c_fe_flag: cover property ($rose(statusBits[BIT_FOLLOW_ERR]));
    c_pos_reached: cover property (posMode && $rose(statusBits[BIT_TARGET_REACHED]));
    c_vel_reached: cover property (pvMode && $rose(statusBits[BIT_TARGET_REACHED]));
    c_moving: cover property ($fell(statusBits[BIT_ZERO_SPEED]));
    c_refused: cover property (objAbort);
endmodule

//--- verif/mwm_host_model.sv
`timescale 1ns/1ps
module mwm_host_model (
    // Clock
    input  wire logic        clk,
    // Object requests
    output logic             objRdEn,
    output logic             objWrEn,
    output logic [15:0]      objIndex,
    output logic [31:0]      objWrData,
    // Answers
    input  wire logic [31:0] objRdData,
    input  wire logic        objAck,
    input  wire logic        objAbort
);
    initial begin
        objRdEn   = 1'h0;
        objWrEn   = 1'h0;
        objIndex  = 16'h0000;
        objWrData = 32'h00000000;
    end

    // One-cycle request; enables drop to 0, index and data go to their inverse, not the old value
    task automatic access(input logic wr, input logic [15:0] idx, input logic [31:0] d,
                          output logic ack, output logic abt, output logic [31:0] q);
        @(posedge clk);
        objWrEn   <= wr;
        objRdEn   <= ~wr;
        objIndex  <= idx;
        objWrData <= d;
        @(posedge clk);
        objWrEn   <= 1'h0;
        objRdEn   <= 1'h0;
        objIndex  <= ~idx;
        objWrData <= ~d;
        @(negedge clk);
        ack = objAck;
        abt = objAbort;
        q   = objRdData;
    endtask
endmodule

//--- verif/motion_window_monitor_tb.sv
`timescale 1ns/1ps
module motion_window_monitor_tb;
    import mwm_pkg::*;
    localparam int MS = 10;
    typedef struct {
        logic        wr;
        logic [15:0] idx;
        logic [31:0] d;
        logic        abt;
        logic [31:0] q;
    } mwm_row_t;
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic objRdEn, objWrEn, objAck, objAbort, feReactionEn, errorLogPulse, ack, abt;
    logic [15:0] objIndex, statusBits;
    logic [31:0] objWrData, objRdData, followErrWindow, q;
    logic [7:0] opMode;
    logic signed [31:0] positionDemand, positionActual, targetPosition;
    logic signed [31:0] speedDemand, speedActual, targetSpeed;
    int errors = 0;
    int n_compared = 0;
    int logCount = 0;
    logic [7:0] posModes [2] = '{MODE_PROFILE_POS, MODE_INTERP_POS};
    // Table also leaves the timers programmed for the hand-written tests
    mwm_row_t rows [19] = '{
        '{1'h0, IDX_FE_TIMEOUT, 32'h0, 1'h0, 32'h00000064},
        '{1'h0, IDX_POS_WINDOW, 32'h0, 1'h0, 32'h0000000A},
        '{1'h0, IDX_POS_TIME, 32'h0, 1'h0, 32'h00000064},
        '{1'h0, IDX_VEL_WINDOW, 32'h0, 1'h0, 32'h0000001E},
        '{1'h0, IDX_VEL_TIME, 32'h0, 1'h0, 32'h00000000},
        '{1'h0, IDX_THR, 32'h0, 1'h0, 32'h00000000},
        '{1'h0, IDX_THR_TIME, 32'h0, 1'h0, 32'h00000000},
        '{1'h0, IDX_SPEED_MEASURED, 32'h0, 1'h0, 32'h00000000},
        '{1'h0, IDX_SPEED_SETPOINT, 32'h0, 1'h0, 32'hFFFFFF38},
        '{1'h1, IDX_SPEED_MEASURED, 32'h5, 1'h1, 32'h0},
        '{1'h1, IDX_SPEED_SETPOINT, 32'h5, 1'h1, 32'h0},
        '{1'h0, 16'h6071, 32'h0, 1'h1, 32'h00000000},
        '{1'h1, IDX_FE_TIMEOUT, 32'hFFFF0003, 1'h0, 32'h0},
        '{1'h0, IDX_FE_TIMEOUT, 32'h0, 1'h0, 32'h00000003},
        '{1'h1, IDX_POS_TIME, 32'h2, 1'h0, 32'h0},
        '{1'h1, IDX_THR, 32'h258, 1'h0, 32'h0},
        '{1'h1, IDX_THR_TIME, 32'h1, 1'h0, 32'h0},
        '{1'h1, IDX_VEL_TIME, 32'h2, 1'h0, 32'h0},
        '{1'h0, IDX_THR, 32'h0, 1'h0, 32'h00000258}
    };

    always #20 clk = ~clk;
    always @(negedge clk) if (errorLogPulse === 1'h1) logCount++;

    mwm_host_model host (.clk(clk), .objRdEn(objRdEn), .objWrEn(objWrEn), .objIndex(objIndex),
        .objWrData(objWrData), .objRdData(objRdData), .objAck(objAck), .objAbort(objAbort));

    mwm_window_monitor #(.MS_CYCLES(MS)) dut (.clk(clk), .rst_n(rst_n), .objRdEn(objRdEn),
        .objWrEn(objWrEn), .objIndex(objIndex), .objWrData(objWrData), .objRdData(objRdData),
        .objAck(objAck), .objAbort(objAbort), .opMode(opMode), .positionDemand(positionDemand),
        .positionActual(positionActual), .targetPosition(targetPosition),
        .speedDemand(speedDemand), .speedActual(speedActual), .targetSpeed(targetSpeed),
        .followErrWindow(followErrWindow), .feReactionEn(feReactionEn),
        .statusBits(statusBits), .errorLogPulse(errorLogPulse));

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_compared++;
        if (g !== e) begin
            $display("[ERR] %s expected %h seen %h", nm, e, g);
            errors++;
        end
    endtask

    // Bounded wait; too early counts as badly as too late
    task automatic waitBit(input string nm, input int b, input logic v, input int lo, input int hi);
        int n;
        n = 0;
        while (n < hi && statusBits[b] !== v) begin
            @(negedge clk);
            n++;
        end
        n_compared++;
        if (statusBits[b] !== v || n < lo) begin
            $display("[ERR] %s expected %0d..%0d cycles seen %0d", nm, lo, hi, n);
            errors++;
            // A bit that never came leaves the later tests meaningless
            if (statusBits[b] !== v) begin
                end_sim();
            end
        end
    endtask

    task automatic holdBit(input string nm, input int b, input logic v, input int cyc);
        logic bad;
        bad = 1'h0;
        repeat (cyc) begin
            @(negedge clk);
            if (statusBits[b] !== v) bad = 1'h1;
        end
        check(nm, {31'h0, v}, {31'h0, v ^ bad});
    endtask

    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial begin
        opMode = 8'h00;
        positionDemand = 32'h0;
        positionActual = 32'h0;
        targetPosition = 32'h0;
        speedDemand = 32'hFFFFFF38;
        speedActual = 32'h0;
        targetSpeed = 32'h0;
        followErrWindow = 32'h64;
        feReactionEn = 1'h1;
        repeat (4) @(posedge clk);
        rst_n <= 1'h1;
        check("statusBits", 32'h1000, {16'h0, statusBits});
        foreach (rows[i]) begin
            host.access(rows[i].wr, rows[i].idx, rows[i].d, ack, abt, q);
            check("objAbort", {31'h0, rows[i].abt}, {31'h0, abt});
            check("objAck", {31'h0, ~rows[i].abt}, {31'h0, ack});
            if (!rows[i].wr) check("objRdData", rows[i].q, q);
        end
        $display("test table done");
        @(posedge clk) positionActual <= 32'h64;
        holdBit("fe at window", BIT_FOLLOW_ERR, 1'h0, 60);
        @(posedge clk) positionActual <= 32'hFFFFFF9B;
        waitBit("fe set", BIT_FOLLOW_ERR, 1'h1, 3 * MS, 4 * MS + 5);
        @(posedge clk) followErrWindow <= WINDOW_OFF;
        waitBit("fe off", BIT_FOLLOW_ERR, 1'h0, 0, 4);
        holdBit("fe stays off", BIT_FOLLOW_ERR, 1'h0, 40);
        check("log pulses", 32'h1, logCount);
        @(posedge clk);
        feReactionEn <= 1'h0;
        followErrWindow <= 32'h64;
        waitBit("fe unlogged", BIT_FOLLOW_ERR, 1'h1, 3 * MS, 4 * MS + 5);
        check("log pulses unlogged", 32'h1, logCount);
        @(posedge clk) followErrWindow <= WINDOW_OFF;
        waitBit("fe off again", BIT_FOLLOW_ERR, 1'h0, 0, 4);
        $display("test following error done");
        foreach (posModes[k]) begin
            @(posedge clk);
            opMode <= posModes[k];
            targetPosition <= 32'h3E8;
            positionActual <= 32'h3F2;
            holdBit("pos at window", BIT_TARGET_REACHED, 1'h0, 40);
            @(posedge clk) positionActual <= 32'h3DF;
            waitBit("pos reached", BIT_TARGET_REACHED, 1'h1, 2 * MS, 3 * MS + 5);
            @(posedge clk) positionActual <= 32'h3F2;
            waitBit("pos lost", BIT_TARGET_REACHED, 1'h0, 0, 4);
        end
        host.access(1'h1, IDX_POS_WINDOW, WINDOW_OFF, ack, abt, q);
        @(posedge clk) positionActual <= 32'h3E8;
        holdBit("pos window off", BIT_TARGET_REACHED, 1'h0, 50);
        $display("test position done");
        @(posedge clk);
        opMode <= MODE_PROFILE_VEL;
        speedActual <= 32'h258;
        holdBit("zero at threshold", BIT_ZERO_SPEED, 1'h1, 40);
        @(posedge clk) speedActual <= 32'hFFFFFDA7;
        waitBit("moving", BIT_ZERO_SPEED, 1'h0, MS, 2 * MS + 6);
        @(posedge clk) targetSpeed <= 32'hFFFFFDBC;
        waitBit("speed reached", BIT_TARGET_REACHED, 1'h1, 2 * MS, 3 * MS + 6);
        host.access(1'h0, IDX_SPEED_MEASURED, 32'h0, ack, abt, q);
        check("measured speed", 32'hFFFFFDA7, q);
        @(posedge clk) speedActual <= 32'hFFFFFDDA;
        waitBit("speed at window", BIT_TARGET_REACHED, 1'h0, 0, 5);
        waitBit("zero again", BIT_ZERO_SPEED, 1'h1, 0, 5);
        $display("test speed done");
        @(posedge clk) rst_n <= 1'h0;
        @(negedge clk);
        check("status in reset", 32'h1000, {16'h0, statusBits});
        @(posedge clk) rst_n <= 1'h1;
        host.access(1'h0, IDX_FE_TIMEOUT, 32'h0, ack, abt, q);
        check("timeout after reset", 32'h00000064, q);
        waitBit("moving at zero time", BIT_ZERO_SPEED, 1'h0, MS - 4, MS + 4);
        $display("test second reset done");
        end_sim();
    end
endmodule
